/* File: sfprp_defs.svh */
// constants for the serial flash program, read and protect block
// Function
// - status write starts timed cycle; latch clears at its end
// - status write updates both protect bits
// - lock bit high, pin low: hardware protected
// - hardware protected mode refuses status writes
// - software mode: writable once latch is set
// - lock bit low: pin level is ignored
// - lock high, pin low rejects status writes
// - protected mode entered in either order
// - protected mode left only by pin high
// - read takes opcode, address, then outputs data
// - read address increments and wraps to zero
// - read ends anytime; rejected while busy
// - fast read adds dummy byte; rejected busy
// - program clears bits only; needs latch set
// - program data wraps within its page
// - over 256 bytes keeps final 256
// - under 256 bytes leaves others untouched
// - select must rise on byte boundary
// - program starts timed cycle, clears latch
// - no program into a protected region
// - status bits six to four read zero
// - write disable and completions clear latch
`ifndef SFPRP_DEFS_SVH
`define SFPRP_DEFS_SVH

`define SFPRP_OP_WREN 8'h06
`define SFPRP_OP_WRDI 8'h04
`define SFPRP_OP_RDSR 8'h05
`define SFPRP_OP_WRSR 8'h01
`define SFPRP_OP_READ 8'h03
`define SFPRP_OP_FAST 8'h0b
`define SFPRP_OP_PP 8'h02

`define SFPRP_ST_LOCK 7
`define SFPRP_ST_BPH 3
`define SFPRP_ST_BPL 2
`define SFPRP_PAGE_BYTES 256
`define SFPRP_ADDR_ZERO 24'h00_0000

`define SFPRP_CLK_MHZ 100
`define SFPRP_PP_TIME_US 100
`define SFPRP_WS_TIME_US 100
`define SFPRP_PP_CYCLES (`SFPRP_PP_TIME_US * `SFPRP_CLK_MHZ)
`define SFPRP_WS_CYCLES (`SFPRP_WS_TIME_US * `SFPRP_CLK_MHZ)

`endif

/* File: sfprp_pkg.sv */
// types for the serial flash program, read and protect block
package sfprp_pkg;

    typedef enum logic [2:0]
    {
        SFPRP_CMD,
        SFPRP_ADDR,
        SFPRP_DUMMY,
        SFPRP_RD_DATA,
        SFPRP_RD_STAT,
        SFPRP_WS_DATA,
        SFPRP_PP_DATA,
        SFPRP_WAIT_END
    } sfprp_phase_t;

    typedef enum logic [1:0]
    {
        SFPRP_IDLE,
        SFPRP_BUSY_WS,
        SFPRP_BUSY_PP
    } sfprp_busy_t;

    typedef struct packed
    {
        logic [2:0] rst_sync;
        logic [2:0] cs_s;
        logic [2:0] sk_s;
        logic [2:0] sd_s;
        logic [2:0] wp_s;
        logic cs_f;
        logic sk_f;
        logic sd_f;
        logic wp_f;
        sfprp_phase_t phase;
        logic [7:0] op;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic [23:0] addr;
        logic [1:0] acnt;
        logic fast;
        logic got_data;
        logic [7:0] ws_val;
        logic [2:0] obit;
        logic [7:0] osh;
        logic so;
        logic lock;
        logic [1:0] bp;
        logic write_enable_latch;
        sfprp_busy_t busy;
        logic [31:0] tcnt;
        logic [8:0] cidx;
        logic [23:0] paddr;
        logic ignore;
    } sfprp_core_t;

endpackage

/* File: sfprp_store_if.sv */
// carrier between the command logic and the storage module
`timescale 1ns/100ps
`default_nettype none
interface sfprp_store_if #(parameter int AW = 12);
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic buf_clr;
    logic buf_we;
    logic [7:0] buf_col;
    logic [7:0] buf_data;
    logic cm_we;
    logic [AW-1:0] cm_addr;

    modport ctrl (output rd_addr, buf_clr, buf_we, buf_col, buf_data, cm_we, cm_addr,
        input rd_data);
    modport store (input rd_addr, buf_clr, buf_we, buf_col, buf_data, cm_we, cm_addr,
        output rd_data);
endinterface
`default_nettype wire

/* File: sfprp_store.sv */
// memory array and page buffer of the serial flash
`timescale 1ns/100ps
`default_nettype none
`include "sfprp_defs.svh"
module sfprp_store import sfprp_pkg::*; #(
    parameter int AW = 12
)(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    sfprp_store_if.store bus
);
    localparam int DEPTH = 1 << AW;

    typedef struct packed
    {
        logic [DEPTH-1:0][7:0] mem;
        logic [`SFPRP_PAGE_BYTES-1:0][7:0] pbuf;
        logic [`SFPRP_PAGE_BYTES-1:0] mask;
    } sfprp_store_t;

    sfprp_store_t st;
    sfprp_store_t next_st;

    assign bus.rd_data = st.mem[bus.rd_addr];

    always_comb
    begin
        next_st = st;
        if (bus.buf_clr)
        begin
            next_st.mask = '0;
        end
        // later bytes at the same column overwrite earlier ones
        if (bus.buf_we)
        begin
            next_st.pbuf[bus.buf_col] = bus.buf_data;
            next_st.mask[bus.buf_col] = 1'b1;
        end
        // programming only ever clears bits
        if (bus.cm_we && st.mask[bus.cm_addr[7:0]])
        begin
            next_st.mem[bus.cm_addr] = st.mem[bus.cm_addr] & st.pbuf[bus.cm_addr[7:0]];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st.mem <= '1;
            st.pbuf <= '1;
            st.mask <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* File: sfprp_top.sv */
// command logic of the serial flash: status protection, reads, page program
`timescale 1ns/100ps
`default_nettype none
`include "sfprp_defs.svh"
module sfprp_top import sfprp_pkg::*; #(
    parameter int AW = 12,
    parameter int PP_CYCLES = `SFPRP_PP_CYCLES,
    parameter int WS_CYCLES = `SFPRP_WS_CYCLES
)(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_wp_n,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    output logic o_busy_flag,
    output logic o_write_enable_latch,
    output logic o_status_lock_bit,
    output logic [1:0] o_protect_bits,
    output logic o_hardware_protected_mode
);
    sfprp_core_t st;
    sfprp_core_t next_st;
    logic rst_n;
    sfprp_store_if #(.AW(AW)) sif ();

    sfprp_store #(.AW(AW)) u_store (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .bus(sif.store)
    );

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // top quarter, top half or whole array by protect bits
    function automatic logic prot_hit(input logic [1:0] bp, input logic [1:0] top);
        unique case (bp)
            2'b00: prot_hit = 1'b0;
            2'b01: prot_hit = (top == 2'b11);
            2'b10: prot_hit = top[1];
            2'b11: prot_hit = 1'b1;
        endcase
    endfunction

    // filtered level: change counts once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction

    // phases in which the device drives its output
    function automatic logic drives_out(input sfprp_phase_t ph);
        drives_out = (ph == SFPRP_RD_DATA) || (ph == SFPRP_RD_STAT);
    endfunction

    // frame that stopped in the wait phase after the given opcode
    function automatic logic ended_after(input sfprp_phase_t ph, input logic [7:0] op,
        input logic [7:0] code);
        ended_after = (ph == SFPRP_WAIT_END) && (op == code);
    endfunction

    // --------------------------------------------------------------
    // pin filters and edges
    // --------------------------------------------------------------
    logic cs_n_f;
    logic sk_n_f;
    logic sd_n_f;
    logic sk_rise;
    logic sk_fall;
    logic cs_rise;
    logic cs_fall;
    logic hardware_protected_mode;
    logic busy;
    logic [7:0] byte_in;
    logic [7:0] stat;
    logic [7:0] obyte;
    logic [31:0] tlim;

    assign rst_n = st.rst_sync[2];
    assign cs_n_f = filt(st.cs_s, st.cs_f);
    assign sk_n_f = filt(st.sk_s, st.sk_f);
    assign sd_n_f = filt(st.sd_s, st.sd_f);
    assign sk_rise = !st.cs_f && sk_n_f && !st.sk_f;
    assign sk_fall = !st.cs_f && !sk_n_f && st.sk_f;
    assign cs_rise = cs_n_f && !st.cs_f;
    assign cs_fall = !cs_n_f && st.cs_f;

    // --------------------------------------------------------------
    // status and shift data
    // --------------------------------------------------------------
    assign hardware_protected_mode = st.lock && !st.wp_f;
    assign busy = (st.busy != SFPRP_IDLE);
    assign byte_in = {st.sh[6:0], sd_n_f};
    assign stat = {st.lock, 3'b000, st.bp, st.write_enable_latch, busy};
    // both self-timed cycles share one counter
    assign tlim = (st.busy == SFPRP_BUSY_PP) ? PP_CYCLES : WS_CYCLES;
    assign obyte = (st.phase == SFPRP_RD_STAT) ? stat : sif.rd_data;

    // --------------------------------------------------------------
    // storage connections
    // --------------------------------------------------------------
    assign sif.rd_addr = st.addr[AW-1:0];
    assign sif.buf_clr = sk_rise && (st.phase == SFPRP_ADDR) && (st.acnt == 2'd2)
        && (st.bitc == 3'd7) && (st.op == `SFPRP_OP_PP);
    assign sif.buf_we = sk_rise && (st.phase == SFPRP_PP_DATA) && (st.bitc == 3'd7);
    assign sif.buf_col = st.addr[7:0];
    assign sif.buf_data = byte_in;
    assign sif.cm_we = (st.busy == SFPRP_BUSY_PP) && !st.cidx[8];
    assign sif.cm_addr = {st.paddr[AW-1:8], st.cidx[7:0]};

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.rst_sync = {st.rst_sync[1:0], 1'b1};
        next_st.cs_s = {st.cs_s[1:0], i_cs_n};
        next_st.sk_s = {st.sk_s[1:0], i_sclk};
        next_st.sd_s = {st.sd_s[1:0], i_serial_in};
        next_st.wp_s = {st.wp_s[1:0], i_wp_n};
        next_st.cs_f = cs_n_f;
        next_st.sk_f = sk_n_f;
        next_st.sd_f = sd_n_f;
        next_st.wp_f = filt(st.wp_s, st.wp_f);

        // new frame: clear counters and accept bits again
        if (cs_fall)
        begin
            next_st.phase = SFPRP_CMD;
            next_st.bitc = 3'd0;
            next_st.obit = 3'd0;
            next_st.acnt = 2'd0;
            next_st.ignore = 1'b0;
            next_st.got_data = 1'b0;
        end

        // incoming bit on each rising link clock edge
        if (sk_rise && !st.ignore)
        begin
            next_st.sh = byte_in;
            next_st.bitc = st.bitc + 3'd1;
            if (st.bitc == 3'd7)
            begin
                unique case (st.phase)
                    SFPRP_CMD:
                    begin
                        next_st.op = byte_in;
                        next_st.fast = (byte_in == `SFPRP_OP_FAST);
                        if (byte_in == `SFPRP_OP_RDSR)
                        begin
                            next_st.phase = SFPRP_RD_STAT;
                        end
                        else if (busy)
                        begin
                            next_st.ignore = 1'b1;
                        end
                        else if (byte_in == `SFPRP_OP_WREN || byte_in == `SFPRP_OP_WRDI)
                        begin
                            next_st.phase = SFPRP_WAIT_END;
                        end
                        else if (byte_in == `SFPRP_OP_WRSR)
                        begin
                            next_st.phase = SFPRP_WS_DATA;
                        end
                        else if (byte_in == `SFPRP_OP_READ || byte_in == `SFPRP_OP_FAST)
                        begin
                            next_st.phase = SFPRP_ADDR;
                        end
                        else if (byte_in == `SFPRP_OP_PP && st.write_enable_latch)
                        begin
                            next_st.phase = SFPRP_ADDR;
                        end
                        else
                        begin
                            next_st.ignore = 1'b1;
                        end
                    end
                    SFPRP_ADDR:
                    begin
                        next_st.addr = {st.addr[15:0], byte_in};
                        next_st.acnt = st.acnt + 2'd1;
                        if (st.acnt == 2'd2)
                        begin
                            if (st.op == `SFPRP_OP_PP)
                            begin
                                next_st.phase = SFPRP_PP_DATA;
                            end
                            else if (st.fast)
                            begin
                                next_st.phase = SFPRP_DUMMY;
                            end
                            else
                            begin
                                next_st.phase = SFPRP_RD_DATA;
                            end
                        end
                    end
                    SFPRP_DUMMY:
                    begin
                        next_st.phase = SFPRP_RD_DATA;
                    end
                    SFPRP_WS_DATA:
                    begin
                        next_st.ws_val = byte_in;
                        next_st.phase = SFPRP_WAIT_END;
                    end
                    SFPRP_PP_DATA:
                    begin
                        // column wraps inside the page
                        next_st.addr[7:0] = st.addr[7:0] + 8'd1;
                        next_st.got_data = 1'b1;
                    end
                    SFPRP_WAIT_END:
                    begin
                        next_st.ignore = 1'b1;
                    end
                    SFPRP_RD_DATA, SFPRP_RD_STAT:
                    begin
                        next_st.ignore = st.ignore;
                    end
                endcase
            end
        end

        // outgoing bit on each falling link clock edge
        if (sk_fall && drives_out(st.phase))
        begin
            next_st.obit = st.obit + 3'd1;
            if (st.obit == 3'd0)
            begin
                next_st.so = obyte[7];
                next_st.osh = {obyte[6:0], 1'b0};
            end
            else
            begin
                next_st.so = st.osh[7];
                next_st.osh = {st.osh[6:0], 1'b0};
            end
            if (st.phase == SFPRP_RD_DATA && st.obit == 3'd7)
            begin
                next_st.addr = st.addr + 24'h00_0001;
            end
        end

        // frame end: execute only on an exact byte boundary
        if (cs_rise)
        begin
            next_st.phase = SFPRP_CMD;
            next_st.ignore = 1'b1;
            if (!st.ignore && st.bitc == 3'd0)
            begin
                if (ended_after(st.phase, st.op, `SFPRP_OP_WREN))
                begin
                    next_st.write_enable_latch = 1'b1;
                end
                if (ended_after(st.phase, st.op, `SFPRP_OP_WRDI))
                begin
                    next_st.write_enable_latch = 1'b0;
                end
                if (ended_after(st.phase, st.op, `SFPRP_OP_WRSR)
                    && st.write_enable_latch && !hardware_protected_mode)
                begin
                    next_st.busy = SFPRP_BUSY_WS;
                    next_st.tcnt = 32'd0;
                end
                if (st.phase == SFPRP_PP_DATA && st.got_data
                    && !prot_hit(st.bp, st.addr[AW-1:AW-2]))
                begin
                    next_st.busy = SFPRP_BUSY_PP;
                    next_st.tcnt = 32'd0;
                    next_st.cidx = 9'd0;
                    next_st.paddr = st.addr;
                    next_st.write_enable_latch = 1'b0;
                end
            end
        end

        // self-timed cycle
        if (busy)
        begin
            next_st.tcnt = st.tcnt + 32'd1;
            if (st.busy == SFPRP_BUSY_PP && !st.cidx[8])
            begin
                next_st.cidx = st.cidx + 9'd1;
            end
            if (st.tcnt >= tlim - 32'd1)
            begin
                next_st.busy = SFPRP_IDLE;
                next_st.write_enable_latch = 1'b0;
                if (st.busy == SFPRP_BUSY_WS)
                begin
                    next_st.lock = st.ws_val[`SFPRP_ST_LOCK];
                    next_st.bp = {st.ws_val[`SFPRP_ST_BPH], st.ws_val[`SFPRP_ST_BPL]};
                end
            end
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st <= '0;
            st.cs_s <= 3'b111;
            st.cs_f <= 1'b1;
            st.wp_s <= 3'b111;
            st.wp_f <= 1'b1;
            st.ignore <= 1'b1;
            st.phase <= SFPRP_CMD;
            st.busy <= SFPRP_IDLE;
        end
        else
        begin
            st <= next_st;
            // cycle and latch stay idle until the synchronised reset lifts
            if (!rst_n)
            begin
                st.busy <= SFPRP_IDLE;
                st.write_enable_latch <= 1'b0;
                st.ignore <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign o_serial_out = st.so;
    assign o_serial_out_oe = !st.cs_f && drives_out(st.phase);
    assign o_busy_flag = busy;
    assign o_write_enable_latch = st.write_enable_latch;
    assign o_status_lock_bit = st.lock;
    assign o_protect_bits = st.bp;
    assign o_hardware_protected_mode = hardware_protected_mode;
endmodule
`default_nettype wire

/* File: sfprp_top_props.sv */
// port assertions for the serial flash command block
`timescale 1ns/100ps
`default_nettype none
module sfprp_top_props #(
    parameter int PP_CYCLES = 300,
    parameter int WS_CYCLES = 300
)(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_wp_n,
    input wire logic o_serial_out,
    input wire logic o_serial_out_oe,
    input wire logic o_busy_flag,
    input wire logic o_write_enable_latch,
    input wire logic o_status_lock_bit,
    input wire logic [1:0] o_protect_bits,
    input wire logic o_hardware_protected_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------
    // busy length counter
    // ------------------------------------------------------------
    logic [31:0] bcnt;
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            bcnt <= 32'h0000_0000;
        else
            bcnt <= o_busy_flag ? bcnt + 32'h0000_0001 : 32'h0000_0000;
    end
    sequence s_busy_start;
        $rose(o_busy_flag);
    endsequence
    sequence s_busy_end;
        $fell(o_busy_flag);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    busy_on_desel_a: assert property (s_busy_start |-> i_cs_n)
        else $error("busy rose while selected");
    busy_hold_a: assert property (s_busy_start |-> o_busy_flag [*8])
        else $error("busy cycle too short");
    busy_bound_a: assert property (bcnt <= PP_CYCLES + WS_CYCLES + 8)
        else $error("busy cycle never ends");
    wel_clear_a: assert property (s_busy_end |-> !o_write_enable_latch)
        else $error("latch still set after cycle");
    wel_idle_a: assert property ($rose(o_write_enable_latch) |-> !o_busy_flag)
        else $error("latch set while busy");
    stat_update_a: assert property (($changed(o_status_lock_bit) || $changed(o_protect_bits))
        |-> $past(o_busy_flag) || $past(o_busy_flag, 2)) else $error("status changed off cycle");
    hpm_lock_a: assert property (o_hardware_protected_mode |-> o_status_lock_bit)
        else $error("protected mode without lock");
    hpm_exit_a: assert property (i_wp_n [*7] |-> !o_hardware_protected_mode)
        else $error("protected mode with pin high");
    oe_desel_a: assert property (i_cs_n [*6] |-> !o_serial_out_oe)
        else $error("output driven while deselected");
    so_fall_a: assert property ((o_serial_out_oe && $past(o_serial_out_oe)
        && $changed(o_serial_out)) |-> !i_sclk) else $error("output moved with clock high");
endmodule
bind sfprp_top sfprp_top_props #(.PP_CYCLES(PP_CYCLES), .WS_CYCLES(WS_CYCLES)) i_props (
    .i_core_clk, .i_nrst, .i_cs_n, .i_sclk, .i_serial_in, .i_wp_n, .o_serial_out,
    .o_serial_out_oe, .o_busy_flag, .o_write_enable_latch, .o_status_lock_bit,
    .o_protect_bits, .o_hardware_protected_mode);
`default_nettype wire

/* File: sfprp_host.sv */
// host link controller model driving the serial flash pins
`timescale 1ns/100ps
`default_nettype none
module sfprp_host (
    input wire logic i_core_clk,
    input wire logic i_serial_out,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_serial_in
);
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_serial_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // clock stands low outside frames
    task automatic sel();
        tick(1);
        o_cs_n = 1'b0;
        tick(8);
    endtask
    task automatic desel();
        tick(4);
        o_cs_n = 1'b1;
        o_serial_in = ~o_serial_in;
        tick(10);
    endtask
    // msb first, sampled before each rise; nb below 8 ends mid-byte
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            o_serial_in = tx[i];
            tick(8);
            rx = {rx[6:0], i_serial_out};
            o_sclk = 1'b1;
            tick(8);
            o_sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: test_serial_flash_program_read_protect.sv */
// self-checking bench of the serial flash command block
`timescale 1ns/100ps
`default_nettype none
`include "sfprp_defs.svh"
`define SFP_CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module test_serial_flash_program_read_protect;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sclk, si, so, so_oe, busy, write_enable_latch, lock, hardware_protected_mode;
    logic [1:0] bp;
    wire logic so_pin = so_oe ? so : ~so;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    string name_q[$];
    logic [7:0] seen, m_exp;
    string m_nm;
    event got;
    logic [31:0] rs = 32'h0000_0017;
    sfprp_top #(.AW(12), .PP_CYCLES(300), .WS_CYCLES(300)) i_dut (.i_core_clk(clk),
        .i_nrst(nrst), .i_cs_n(cs_n), .i_sclk(sclk), .i_serial_in(si), .i_wp_n(wp_n),
        .o_serial_out(so), .o_serial_out_oe(so_oe), .o_busy_flag(busy),
        .o_write_enable_latch(write_enable_latch), .o_status_lock_bit(lock), .o_protect_bits(bp),
        .o_hardware_protected_mode(hardware_protected_mode));
    sfprp_host i_host (.i_core_clk(clk), .i_serial_out(so_pin), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_serial_in(si));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // result monitor and closing
    // ------------------------------------------------------------
    always @(got)
    begin
        m_exp = exp_q.pop_front();
        m_nm = name_q.pop_front();
        `SFP_CHK(m_nm, m_exp, seen)
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            err_count++;
            conclude();
        end
    end
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    // ------------------------------------------------------------
    // link operations
    // ------------------------------------------------------------
    task automatic note(input string nm, input logic [7:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
    endtask
    task automatic get(input int n);
        logic [7:0] r;
        repeat (n)
        begin
            i_host.xfer(8'h00, 8, r);
            seen = r;
            -> got;
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na);
        logic [7:0] r;
        i_host.sel();
        i_host.xfer(op, 8, r);
        for (int i = na - 1; i >= 0; i--)
            i_host.xfer(a[8*i +: 8], 8, r);
    endtask
    task automatic one(input logic [7:0] op);
        cmd(op, 24'h00_0000, 0);
        i_host.desel();
    endtask
    task automatic idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++)
            @(posedge clk);
        #1;
    endtask
    task automatic stat(input logic [7:0] e);
        note("status", e);
        cmd(`SFPRP_OP_RDSR, 24'h00_0000, 0);
        get(1);
        i_host.desel();
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
        logic [7:0] r;
        cmd(op, a, 3);
        if (op == `SFPRP_OP_FAST)
            i_host.xfer(8'h00, 8, r);
        get(n);
        i_host.desel();
    endtask
    task automatic wsr(input logic [7:0] v);
        one(`SFPRP_OP_WREN);
        cmd(`SFPRP_OP_WRSR, {16'h0000, v}, 1);
        i_host.desel();
        idle();
    endtask
    task automatic pp(input logic [23:0] a, input logic [7:0] d[$], input int tail);
        logic [7:0] r;
        cmd(`SFPRP_OP_PP, a, 3);
        foreach (d[i])
            i_host.xfer(d[i], 8, r);
        if (tail > 0)
            i_host.xfer(8'hff, tail, r);
        i_host.desel();
        idle();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] d[$];
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (10) @(posedge clk);
        stat(8'h00);
        cmd(`SFPRP_OP_WRSR, 24'h00_008c, 1);
        i_host.desel();
        stat(8'h00);
        one(`SFPRP_OP_WREN);
        stat(8'h02);
        one(`SFPRP_OP_WRDI);
        stat(8'h00);
        one(`SFPRP_OP_WREN);
        cmd(`SFPRP_OP_WRSR, 24'h00_00fc, 1);
        i_host.desel();
        stat(8'h03);
        idle();
        stat(8'h8c);
        wp_n = 1'b0;
        i_host.tick(8);
        `SFP_CHK("hpm", 1'b1, hardware_protected_mode)
        wsr(8'h00);
        stat(8'h8e);
        `SFP_CHK("flags", 5'h1e, {lock, bp, write_enable_latch, busy})
        wp_n = 1'b1;
        i_host.tick(8);
        `SFP_CHK("hpm", 1'b0, hardware_protected_mode)
        wsr(8'h00);
        stat(8'h00);
        wp_n = 1'b0;
        wsr(8'h84);
        stat(8'h84);
        `SFP_CHK("hpm", 1'b1, hardware_protected_mode)
        wp_n = 1'b1;
        wsr(8'h00);
        $display("test protect done");
        d = {rnd(), rnd(), rnd()};
        one(`SFPRP_OP_WREN);
        pp(24'h00_00fe, d, 0);
        note("mem", d[0]);
        note("mem", d[1]);
        note("mem", 8'hff);
        rd(`SFPRP_OP_READ, 24'h00_00fe, 3);
        note("mem", 8'hff);
        note("mem", d[2]);
        rd(`SFPRP_OP_READ, 24'hff_ffff, 2);
        note("mem", d[0]);
        rd(`SFPRP_OP_FAST, 24'h00_00fe, 1);
        pp(24'h00_0010, {8'h00}, 0);
        note("mem", 8'hff);
        rd(`SFPRP_OP_READ, 24'h00_0010, 1);
        one(`SFPRP_OP_WREN);
        pp(24'h00_00fe, {8'hf0}, 0);
        note("mem", d[0] & 8'hf0);
        rd(`SFPRP_OP_READ, 24'h00_00fe, 1);
        one(`SFPRP_OP_WREN);
        pp(24'h00_0030, {8'h00}, 4);
        note("mem", 8'hff);
        rd(`SFPRP_OP_READ, 24'h00_0030, 1);
        stat(8'h02);
        wsr(8'h0c);
        one(`SFPRP_OP_WREN);
        pp(24'h00_0020, {8'h00}, 0);
        note("mem", 8'hff);
        rd(`SFPRP_OP_READ, 24'h00_0020, 1);
        wsr(8'h00);
        $display("test program done");
        d = {};
        for (int k = 0; k <= 256; k++)
            d.push_back(k == 256 ? 8'ha1 : k[7:0]);
        one(`SFPRP_OP_WREN);
        pp(24'h00_0200, d, 0);
        note("mem", 8'ha1);
        note("mem", 8'h01);
        rd(`SFPRP_OP_READ, 24'h00_0200, 2);
        $display("test long page done");
        conclude();
    end
endmodule
`default_nettype wire
